// ===== gpp_pkg.sv
// Package: register map, field positions and constants of the GPIO port block
package gpp_pkg;

   // ------------------------------------------------------------
   // Register indices as printed; byte address is index * 4
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_STATUS    = 8'h03;
   localparam logic [7:0] IDX_PORT      = 8'h05;
   localparam logic [7:0] IDX_OPTION    = 8'h81;
   localparam logic [7:0] IDX_DIR       = 8'h85;
   localparam logic [7:0] IDX_INTCTL    = 8'h0b;
   localparam logic [7:0] IDX_CFG       = 8'h20;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] DIR_RST       = 8'h3f;
   localparam logic [7:0] OPTION_RST    = 8'hff;
   localparam logic [7:0] STATUS_RST    = 8'h18;
   localparam logic [7:0] LATCH_RST     = 8'hc0;
   localparam logic [7:0] INTCTL_RST    = 8'h00;
   localparam logic [7:0] CFG_RST       = 8'h1f;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned PIN_IN_ONLY  = 3;
   localparam int unsigned PIN_OSC2     = 4;
   localparam int unsigned PIN_OSC1     = 5;
   localparam int unsigned PIN_SDA      = 6;
   localparam int unsigned PIN_SCL      = 7;
   localparam int unsigned CHG_EN_BIT   = 3;
   localparam int unsigned CHG_FLAG_BIT = 0;
   localparam int unsigned OPTION_PU_N  = 7;
   // Configuration register: [2:0] osc mode, [3] reset pin, [4] analog
   localparam int unsigned CFG_RST_PIN  = 3;
   localparam int unsigned CFG_ANALOG   = 4;

   // Pins with pull-up and change detection
   localparam logic [5:0] CHG_PINS      = 6'h0b;
   // Pins taken by the analog function
   localparam logic [5:0] ANALOG_PINS   = 6'h17;

   // Oscillator modes
   typedef enum logic [2:0] {
      OSC_LP, OSC_XT, OSC_HS, OSC_INT_RC, OSC_INT_RC_CKO,
      OSC_EXT_RC, OSC_EXT_RC_CKO, OSC_RSVD
   } gpp_osc_t;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage : gpp_pkg

// ===== gpp_sync.sv
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module gpp_sync #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   // A zero-width bus has nothing to carry
   if (W == 0) begin : g_bad_width
      $error("Synchroniser width must be nonzero");
   end

   // First stage feeds only the second
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : gpp_sync

// ===== gpp_axil.sv
// AXI4-Lite slave front end: turns bus transfers into single-cycle strobes
`timescale 1ns/1ns
module gpp_axil (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // AXI4-Lite
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Register strobes
   output logic             wr_en,
   output logic [7:0]       wr_idx,
   output logic [7:0]       wr_data,
   output logic             rd_en,
   output logic [7:0]       rd_idx,
   input  wire logic [7:0]  rd_data,
   input  wire logic        wr_hit,
   input  wire logic        rd_hit
);

   logic        aw_r, w_r, aw_nxt, w_nxt, bv_nxt, rv_nxt;
   logic [11:0] awa_r, awa_nxt;
   logic [7:0]  wd_r, wd_nxt;
   logic [1:0]  bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;

   assign s_axi_awready = !aw_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_en   = aw_r && w_r;
   assign wr_idx  = awa_r[9:2];
   assign wr_data = wd_r;
   assign rd_en   = s_axi_arvalid && s_axi_arready;
   assign rd_idx  = s_axi_araddr[9:2];

   // Address and data may arrive in either order; write fires when both held
   always_comb begin
      aw_nxt    = aw_r;
      w_nxt     = w_r;
      awa_nxt   = awa_r;
      wd_nxt    = wd_r;
      bv_nxt    = s_axi_bvalid;
      bresp_nxt = s_axi_bresp;
      rv_nxt    = s_axi_rvalid;
      rresp_nxt = s_axi_rresp;
      rdata_nxt = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_nxt  = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_nxt  = 1'b1;
         // Registers are one byte wide: only lane 0 matters
         wd_nxt = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_en) begin
         aw_nxt    = 1'b0;
         w_nxt     = 1'b0;
         bv_nxt    = 1'b1;
         bresp_nxt = (wr_hit && awa_r[11:10] == 2'h0)
                     ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         bv_nxt = 1'b0;
      end
      if (rd_en) begin
         rv_nxt    = 1'b1;
         rdata_nxt = {24'h000000, rd_data};
         rresp_nxt = (rd_hit && s_axi_araddr[11:10] == 2'h0)
                     ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         rv_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_r         <= 1'b0;
         w_r          <= 1'b0;
         awa_r        <= 12'h000;
         wd_r         <= 8'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         aw_r         <= aw_nxt;
         w_r          <= w_nxt;
         awa_r        <= awa_nxt;
         wd_r         <= wd_nxt;
         s_axi_bvalid <= bv_nxt;
         s_axi_bresp  <= bresp_nxt;
         s_axi_rvalid <= rv_nxt;
         s_axi_rresp  <= rresp_nxt;
         s_axi_rdata  <= rdata_nxt;
      end
   end

endmodule : gpp_axil

// ===== gpp_port.sv
// General purpose I/O port: data latches, direction, overrides, change detect
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module gpp_port (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Power-on indication: high for the reset that follows power-up
   input  wire logic        por_flag,
   // AXI4-Lite register bus
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // External pins (four signals each)
   input  wire logic [5:0]  pin_in,
   output logic [5:0]       pin_out,
   output logic [5:0]       pin_oe,
   output logic [5:0]       pin_pullup,
   // Internal EEPROM lines (bit 0 data, bit 1 clock)
   input  wire logic [1:0]  ee_in,
   output logic [1:0]       ee_out,
   // Port change interrupt request
   output logic             port_change_irq
);

   // ------------------------------------------------------------
   // Register bus front end
   // ------------------------------------------------------------
   logic       wr_en, rd_en, wr_hit, rd_hit;
   logic [7:0] wr_idx, wr_data, rd_idx, rd_data;

   gpp_axil u_bus (
      .core_clk      (core_clk),
      .arst_n        (arst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_idx        (wr_idx),
      .wr_data       (wr_data),
      .rd_en         (rd_en),
      .rd_idx        (rd_idx),
      .rd_data       (rd_data),
      .wr_hit        (wr_hit),
      .rd_hit        (rd_hit)
   );

   // ------------------------------------------------------------
   // Pin synchronisers: pins and EEPROM lines are asynchronous
   // ------------------------------------------------------------
   logic [7:0] pins_s;

   gpp_sync #(.W(8)) u_sync (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .d        ({ee_in[1], ee_in[0], pin_in}),
      .q        (pins_s)
   );

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] latch_r, latch_nxt;
   logic [7:0] dir_r, dir_nxt;
   logic [7:0] option_r, option_nxt;
   logic [7:0] status_r, status_nxt;
   logic [7:0] intctl_r, intctl_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] snap_r, snap_nxt;
   logic       por_seen_r, por_seen_nxt;

   gpp_pkg::gpp_osc_t osc_mode;
   logic       rc_mode, clk_out_mode, rst_pin_en, analog_en;
   logic [7:0] alt_mask, port_view, dir_view, chg_mask;
   logic       change;

   // Decode of configuration register
   assign osc_mode    = gpp_pkg::gpp_osc_t'(cfg_r[2:0]);
   assign rc_mode      = (osc_mode == gpp_pkg::OSC_INT_RC) ||
                         (osc_mode == gpp_pkg::OSC_INT_RC_CKO) ||
                         (osc_mode == gpp_pkg::OSC_EXT_RC) ||
                         (osc_mode == gpp_pkg::OSC_EXT_RC_CKO);
   assign clk_out_mode = (osc_mode == gpp_pkg::OSC_INT_RC_CKO) ||
                         (osc_mode == gpp_pkg::OSC_EXT_RC_CKO);
   assign rst_pin_en   = cfg_r[gpp_pkg::CFG_RST_PIN];
   assign analog_en   = cfg_r[gpp_pkg::CFG_ANALOG];

   // Pins under an alternate function read as zero
   always_comb begin
      alt_mask = 8'h00;
      if (analog_en)
         alt_mask[5:0] = gpp_pkg::ANALOG_PINS;
      if (rst_pin_en)
         alt_mask[gpp_pkg::PIN_IN_ONLY] = 1'b1;
      if (!rc_mode) begin
         alt_mask[gpp_pkg::PIN_OSC1] = 1'b1;
         alt_mask[gpp_pkg::PIN_OSC2] = 1'b1;
      end else if (clk_out_mode) begin
         alt_mask[gpp_pkg::PIN_OSC2] = 1'b1;
      end
   end

   // Reads see synchronised pins, masked; never the latches
   assign port_view = pins_s & ~alt_mask;

   // Direction readback with fixed bits
   always_comb begin
      dir_view = dir_r;
      dir_view[gpp_pkg::PIN_IN_ONLY] = 1'b1;
      dir_view[gpp_pkg::PIN_SDA] = 1'b0;
      dir_view[gpp_pkg::PIN_SCL] = 1'b0;
      if (!rc_mode) begin
         dir_view[gpp_pkg::PIN_OSC1] = 1'b1;
         dir_view[gpp_pkg::PIN_OSC2] = 1'b1;
      end
   end

   // Change detect pins are fixed but for pin three under the reset pin; the change enable gates only the irq
   always_comb begin
      chg_mask = {2'b00, gpp_pkg::CHG_PINS};
      if (rst_pin_en)
         chg_mask[gpp_pkg::PIN_IN_ONLY] = 1'b0;
   end
   assign change = |((pins_s ^ snap_r) & chg_mask);

   // ------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 8'h00;
      unique case (rd_idx)
         gpp_pkg::IDX_STATUS: rd_data = status_r;
         gpp_pkg::IDX_PORT:   rd_data = port_view;
         gpp_pkg::IDX_OPTION: rd_data = option_r;
         gpp_pkg::IDX_DIR:    rd_data = dir_view;
         gpp_pkg::IDX_INTCTL: rd_data = intctl_r;
         gpp_pkg::IDX_CFG:    rd_data = cfg_r;
         default:             rd_hit  = 1'b0;
      endcase
   end

   always_comb begin
      unique case (wr_idx)
         gpp_pkg::IDX_STATUS, gpp_pkg::IDX_PORT, gpp_pkg::IDX_OPTION,
         gpp_pkg::IDX_DIR, gpp_pkg::IDX_INTCTL, gpp_pkg::IDX_CFG:
            wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Next state of registers
   // ------------------------------------------------------------
   always_comb begin
      latch_nxt    = latch_r;
      dir_nxt      = dir_r;
      option_nxt   = option_r;
      status_nxt   = status_r;
      intctl_nxt   = intctl_r;
      cfg_nxt      = cfg_r;
      snap_nxt     = snap_r;
      por_seen_nxt = por_seen_r;
      // Power-on forces analog mode once, after reset release
      if (por_flag && !por_seen_r) begin
         cfg_nxt[gpp_pkg::CFG_ANALOG] = 1'b1;
         por_seen_nxt = 1'b1;
      end
      if (!por_flag)
         por_seen_nxt = 1'b0;
      // Reading the port refreshes the change reference
      if (rd_en && rd_idx == gpp_pkg::IDX_PORT)
         snap_nxt = pins_s;
      if (wr_en) begin
         unique case (wr_idx)
            // Software composes a read-modify-write from the pin view;
            // the write always lands in all eight latches
            gpp_pkg::IDX_PORT:   latch_nxt = wr_data;
            gpp_pkg::IDX_DIR: begin
               dir_nxt[2:0] = wr_data[2:0];
               if (rc_mode)
                  dir_nxt[gpp_pkg::PIN_OSC1] =
                     wr_data[gpp_pkg::PIN_OSC1];
               if (rc_mode && !clk_out_mode)
                  dir_nxt[gpp_pkg::PIN_OSC2] =
                     wr_data[gpp_pkg::PIN_OSC2];
            end
            gpp_pkg::IDX_OPTION: option_nxt = wr_data;
            gpp_pkg::IDX_STATUS: status_nxt = wr_data;
            gpp_pkg::IDX_INTCTL: intctl_nxt = wr_data;
            gpp_pkg::IDX_CFG:    cfg_nxt    = wr_data;
            default: ;
         endcase
      end
      // Hardware set beats a software clear, enables ignored
      if (change)
         intctl_nxt[gpp_pkg::CHG_FLAG_BIT] = 1'b1;
   end

   // Any reset: direction bits five to zero ones, latches hold unknown-free defaults
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_r    <= gpp_pkg::LATCH_RST;
         dir_r      <= gpp_pkg::DIR_RST;
         option_r   <= gpp_pkg::OPTION_RST;
         status_r   <= gpp_pkg::STATUS_RST;
         intctl_r   <= gpp_pkg::INTCTL_RST;
         cfg_r      <= gpp_pkg::CFG_RST;
         snap_r     <= 8'h00;
         por_seen_r <= 1'b0;
      end else begin
         latch_r    <= latch_nxt;
         dir_r      <= dir_nxt;
         option_r   <= option_nxt;
         status_r   <= status_nxt;
         intctl_r   <= intctl_nxt;
         cfg_r      <= cfg_nxt;
         snap_r     <= snap_nxt;
         por_seen_r <= por_seen_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Driver enabled only where direction is zero and the pin is ours
   always_comb begin
      pin_out = latch_r[5:0];
      pin_oe  = ~dir_view[5:0] & ~alt_mask[5:0];
      pin_oe[gpp_pkg::PIN_IN_ONLY] = 1'b0;
      pin_pullup = {6{~option_r[gpp_pkg::OPTION_PU_N]}} &
                   gpp_pkg::CHG_PINS;
      if (rst_pin_en)
         pin_pullup[gpp_pkg::PIN_IN_ONLY] = 1'b1;
   end

   // EEPROM lines follow their latches; software owns the timing
   assign ee_out = latch_r[gpp_pkg::PIN_SCL:gpp_pkg::PIN_SDA];

   assign port_change_irq = intctl_r[gpp_pkg::CHG_EN_BIT] &
                            intctl_r[gpp_pkg::CHG_FLAG_BIT];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   port_read_pins_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rd_en && rd_idx == gpp_pkg::IDX_PORT |=> s_axi_rdata[7:0] ==
      $past(pins_s & ~alt_mask)) else $error("Port read not pins");
   dir_fixed_bits_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      dir_view[3] && !dir_view[7] && !dir_view[6])
      else $error("Fixed direction bits wrong");
   drive_follows_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      pin_oe[0] == !(dir_r[0] || alt_mask[0]))
      else $error("Pin zero driver mismatch");
   irq_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      port_change_irq |-> intctl_r[gpp_pkg::CHG_EN_BIT])
      else $error("Change irq without enable");
   flag_sets_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      change |=> intctl_r[gpp_pkg::CHG_FLAG_BIT])
      else $error("Change flag not set");
   osc_dir_lock_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !rc_mode |-> dir_view[5:4] == 2'b11 && pin_oe[5:4] == 2'b00)
      else $error("Osc pins not released");
   latch_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !(wr_en && wr_idx == gpp_pkg::IDX_PORT) |=> $stable(latch_r))
      else $error("Latch changed without write");
   master_reset_input_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rst_pin_en |-> !port_view[3] && !chg_mask[3] && pin_pullup[3])
      else $error("Reset pin handling wrong");

endmodule : gpp_port

// ===== gpp_board.sv
// Board model: resolves the level of each external port pin
`timescale 1ns/1ns
module gpp_board (
   // Clock
   input  wire logic       core_clk,
   // Device side
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   input  wire logic [5:0] pin_pullup,
   // Outside drive, strong enough to beat the device driver
   input  wire logic [5:0] ext_val,
   input  wire logic [5:0] ext_en,
   output logic      [5:0] pin_lvl
);
   logic [5:0] last_r = 6'h00;
   // A floating pin wanders, so a stale level is never trusted
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (ext_en[i]) pin_lvl[i] = ext_val[i];
         else if (pin_oe[i]) pin_lvl[i] = pin_out[i];
         else if (pin_pullup[i]) pin_lvl[i] = 1'b1;
         else pin_lvl[i] = ~last_r[i];
      end
   end
   // Last level, for the wandering of floating pins
   always_ff @(posedge core_clk) last_r <= pin_lvl;
endmodule : gpp_board

// ===== testbench.sv
// Testbench: register tasks and port scenarios for the GPIO port block
`timescale 1ns/1ns
module testbench;
   logic        core_clk = 1'b0, arst_n = 1'b0, por_flag = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, port_change_irq;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, ee_out;
   logic [5:0]  pin_in, pin_out, pin_oe, pin_pullup;
   logic [5:0]  ext_val = 6'h3f, ext_en = 6'h3f;
   logic [7:0]  e;
   int          err_total = 0, comparisons = 0;

   gpp_port dut (.core_clk, .arst_n, .por_flag, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
      .pin_out, .pin_oe, .pin_pullup, .ee_in(ee_out), .ee_out,
      .port_change_irq);
   gpp_board board (.core_clk, .pin_out, .pin_oe, .pin_pullup, .ext_val,
      .ext_en, .pin_lvl(pin_in));

   // 125 MHz core clock
   initial forever #4 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      if (err_total == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up

   // Ready and valid are sampled at the rising edge that takes the transfer
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic pa, pw, pb;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40 && pb; n++) begin
         @(posedge core_clk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         pb = pb && !s_axi_bvalid;
         rsp = s_axi_bresp;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
         s_axi_bready <= pb;
      end
      // One idle edge keeps the next call off the edge of this release
      @(posedge core_clk);
      if (pb) err_total++;
      if (pb) wrap_up();
   endtask : wr

   task automatic rd(input logic [7:0] idx);
      logic pa, pr;
      pa = 1'b1;
      pr = 1'b1;
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40 && pr; n++) begin
         @(posedge core_clk);
         pa = pa && !s_axi_arready;
         pr = pr && !s_axi_rvalid;
         rv = s_axi_rdata;
         rsp = s_axi_rresp;
         s_axi_arvalid <= pa;
         s_axi_rready <= pr;
      end
      @(posedge core_clk);
      if (pr) err_total++;
      if (pr) wrap_up();
   endtask : rd

   // Main sequence: power-on reset, then the port scenarios
   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      por_flag <= 1'b0;
      rd(gpp_pkg::IDX_DIR);
      chk(rv, 32'h3f);
      rd(gpp_pkg::IDX_PORT);
      chk(rv, 32'hc0);
      chk({26'h0, pin_pullup}, 32'h08);
      rd(8'h10);
      chk({rv[29:0], rsp}, {30'h0, gpp_pkg::RESP_SLVERR});
      wr(8'h10, 8'h5a);
      chk({30'h0, rsp}, {30'h0, gpp_pkg::RESP_SLVERR});
      // External RC: all direction bits but the fixed ones follow writes
      wr(gpp_pkg::IDX_CFG, 8'h05);
      chk({30'h0, rsp}, {30'h0, gpp_pkg::RESP_OKAY});
      wr(gpp_pkg::IDX_DIR, 8'h00);
      rd(gpp_pkg::IDX_DIR);
      chk(rv, 32'h08);
      chk({26'h0, pin_oe}, 32'h37);
      // EEPROM lines are written back idle high
      wr(gpp_pkg::IDX_PORT, 8'he5);
      chk({26'h0, pin_out}, 32'h25);
      chk({30'h0, ee_out}, 32'h3);
      ext_en <= 6'h08;
      repeat (3) @(posedge core_clk);
      rd(gpp_pkg::IDX_PORT);
      chk(rv, 32'hed);
      // Board holds pin zero low against a high driver
      ext_en <= 6'h09;
      ext_val <= 6'h08;
      repeat (3) @(posedge core_clk);
      rd(gpp_pkg::IDX_PORT);
      chk(rv, 32'hec);
      // Read-modify-write sets bit one; the low pin zero lands in its latch
      wr(gpp_pkg::IDX_PORT, rv[7:0] | 8'h02);
      chk({26'h0, pin_out}, 32'h2e);
      chk({30'h0, ee_out}, 32'h3);
      // Every oscillator mode against direction bits five and four
      for (int m = 0; m < 8; m++) begin
         e = (m == 3 || m == 5) ? 8'h08 : (m == 4 || m == 6) ? 8'h18 : 8'h38;
         wr(gpp_pkg::IDX_CFG, 8'h03);
         wr(gpp_pkg::IDX_DIR, 8'h3f);
         wr(gpp_pkg::IDX_CFG, m[7:0]);
         wr(gpp_pkg::IDX_DIR, 8'h00);
         rd(gpp_pkg::IDX_DIR);
         chk(rv, {24'h0, e});
      end
      wr(gpp_pkg::IDX_CFG, 8'h05);
      wr(gpp_pkg::IDX_OPTION, 8'h7f);
      chk({26'h0, pin_pullup}, 32'h0b);
      // Change detection on pin three with the interrupt disabled, then enabled; pin two sets no flag
      wr(gpp_pkg::IDX_DIR, 8'hff);
      ext_en <= 6'h3f;
      ext_val <= 6'h00;
      repeat (3) @(posedge core_clk);
      rd(gpp_pkg::IDX_PORT);
      wr(gpp_pkg::IDX_INTCTL, 8'h00);
      ext_val <= 6'h08;
      repeat (4) @(posedge core_clk);
      rd(gpp_pkg::IDX_INTCTL);
      chk(rv, 32'h01);
      chk({31'h0, port_change_irq}, 32'h0);
      wr(gpp_pkg::IDX_INTCTL, 8'h09);
      chk({31'h0, port_change_irq}, 32'h1);
      rd(gpp_pkg::IDX_PORT);
      wr(gpp_pkg::IDX_INTCTL, 8'h08);
      ext_val <= 6'h0c;
      repeat (4) @(posedge core_clk);
      rd(gpp_pkg::IDX_INTCTL);
      chk(rv, 32'h08);
      // A reset in mid-run brings direction bits five to zero back to input
      wr(gpp_pkg::IDX_DIR, 8'h00);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(gpp_pkg::IDX_DIR);
      chk(rv, 32'h3f);
      wrap_up();
   end
endmodule : testbench
